// File: core/devcap_map.vh
`ifndef DEVCAP_MAP_VH
`define DEVCAP_MAP_VH

// Byte address of the capability word
`define DEVCAP_OFFSET        12'h044
// Byte address of the lock control word
`define DEVCAP_CTRL_OFFSET   12'h0F0

// Field positions
`define MPS_MSB              2
`define MPS_LSB              0
`define PHANTOM_MSB          4
`define PHANTOM_LSB          3
`define EXT_TAG_BIT          5
`define E0_MSB               8
`define E0_LSB               6
`define E1_MSB               11
`define E1_LSB               9
`define ATTN_BTN_BIT         12
`define ATTN_IND_BIT         13
`define PWR_IND_BIT          14
`define RBER_BIT             15
`define CPV_MSB              25
`define CPV_LSB              18
`define CPS_MSB              27
`define CPS_LSB              26

// Reset values
`define MPS_RESET            3'h4
`define PHANTOM_VALUE        2'h0
`define EXT_TAG_RESET        1'h1
`define LAT_VALUE            3'h0
`define RBER_VALUE           1'h1
`define CPV_RESET            8'h00
`define CPS_RESET            2'h0

// Control word bits: bit 0 unlock
`define CTRL_UNLOCK_BIT      0

`endif

// File: core/device_capabilities_register.v
// Our own choice: register access over Avalon-MM.
`timescale 1ns/1ps
`include "devcap_map.vh"
module device_capabilities_register (
    input  wire        I_CORE_CLK,        // 20 MHz core clock
    input  wire        I_RST_N,           // Async reset, active low
    input  wire        I_UPSTREAM,        // Static: port is upstream
    input  wire        I_MSG_VALID,       // One-cycle power-limit message strobe
    input  wire [7:0]  I_MSG_VALUE,       // Message power value
    input  wire [1:0]  I_MSG_SCALE,       // Message power scale
    input  wire [11:0] I_ADDRESS,         // Avalon byte address
    input  wire        I_READ,            // Avalon read
    input  wire        I_WRITE,           // Avalon write
    input  wire [31:0] I_WRITEDATA,       // Avalon write data
    input  wire [3:0]  I_BYTEENABLE,      // Avalon byte enables
    output reg  [31:0] O_READDATA,        // Avalon read data
    output reg         O_WAITREQUEST      // Avalon waitrequest
);
    // Bus handshake states
    localparam  ST_IDLE   = 1'h0;           // No request taken yet
    localparam  ST_ANSWER = 1'h1;           // Waitrequest low, read data standing

    // Bus side
    reg         state_r;                    // Handshake state
    reg         state_nxt;                  // Next handshake state
    reg         wait_nxt;                   // Next waitrequest
    reg  [31:0] rdata_nxt;                  // Next read data

    // Lockable fields and unlock control
    reg  [2:0]  mps_r;                      // Max payload supported
    reg  [2:0]  mps_nxt;                    // Next max payload supported
    reg         ext_tag_r;                  // Extended tag support
    reg         ext_tag_nxt;                // Next extended tag support
    reg         unlock_r;                   // Lockable fields writable
    reg         unlock_nxt;                 // Next unlock

    // Strap synchroniser
    reg         up_meta_r;                  // First flop, not read by logic
    reg         up_sync_r;                  // Port role, synchronised

    // Capability word and decode
    reg  [31:0] cap_word;                   // Assembled capability word
    wire [7:0]  cap_value;                  // Captured power value
    wire [1:0]  cap_scale;                  // Captured power scale
    wire        take;                       // Request taken this edge
    wire        take_rd;                    // Read taken
    wire        take_wr;                    // Write taken
    wire        sel_cap;                    // Capability word addressed
    wire        sel_ctrl;                   // Control word addressed

    // True when a bus address selects the given register
    function addr_is;
        input [11:0] addr;
        input [11:0] target;
        begin
            addr_is = (addr == target);
        end
    endfunction

    // Write strobe for a register whose writable bits sit in byte lane 0
    function lane0_write;
        input       allowed;
        input [3:0] byte_en;
        begin
            lane0_write = allowed & byte_en[0];
        end
    endfunction

    // Port role comes from a strap pin; two flops before any logic reads it.
    // It reads as downstream for two cycles after reset, when captured fields are zero anyway.
    always @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            up_meta_r <= 1'h0;
            up_sync_r <= 1'h0;
        end else begin
            up_meta_r <= I_UPSTREAM;
            up_sync_r <= up_meta_r;
        end
    end

    // Captured power fields follow the last message, upstream port only
    power_limit_capture power_limit_capture_i (
        .i_clk       (I_CORE_CLK),
        .i_rst_n     (I_RST_N),
        .i_upstream  (up_sync_r),
        .i_msg_valid (I_MSG_VALID),
        .i_msg_value (I_MSG_VALUE),
        .i_msg_scale (I_MSG_SCALE),
        .o_value     (cap_value),
        .o_scale     (cap_scale)
    );

    // A request is taken only when idle, so a request still held in the answer cycle is not taken twice
    assign take     = (state_r == ST_IDLE) & (I_READ | I_WRITE);
    assign take_rd  = take & I_READ;
    assign take_wr  = take & I_WRITE;
    assign sel_cap  = addr_is(I_ADDRESS, `DEVCAP_OFFSET);
    assign sel_ctrl = addr_is(I_ADDRESS, `DEVCAP_CTRL_OFFSET);

    // Read-only bits are constants; only payload, tag and captured power fields vary
    always @* begin
        cap_word                            = 32'h0000_0000;
        cap_word[`MPS_MSB:`MPS_LSB]         = mps_r;
        cap_word[`PHANTOM_MSB:`PHANTOM_LSB] = `PHANTOM_VALUE;
        cap_word[`EXT_TAG_BIT]              = ext_tag_r;
        cap_word[`E0_MSB:`E0_LSB]           = `LAT_VALUE;
        cap_word[`E1_MSB:`E1_LSB]           = `LAT_VALUE;
        cap_word[`ATTN_BTN_BIT]             = 1'h0;
        cap_word[`ATTN_IND_BIT]             = 1'h0;
        cap_word[`PWR_IND_BIT]              = 1'h0;
        cap_word[`RBER_BIT]                 = `RBER_VALUE;
        cap_word[`CPV_MSB:`CPV_LSB]         = cap_value;
        cap_word[`CPS_MSB:`CPS_LSB]         = cap_scale;
    end

    // Handshake: a taken request gets one wait cycle, then waitrequest
    // stays low for exactly one cycle while the master holds its request
    always @* begin
        state_nxt = state_r;
        wait_nxt  = 1'h1;
        case (state_r)
            ST_IDLE: begin
                // Answer in the cycle after the request is seen
                if (I_READ | I_WRITE) begin
                    state_nxt = ST_ANSWER;
                    wait_nxt  = 1'h0;
                end
            end
            ST_ANSWER: begin
                // Master samples waitrequest low at this edge and releases
                state_nxt = ST_IDLE;
                wait_nxt  = 1'h1;
            end
            default: begin
                // Unreachable code; fall back to idle
                state_nxt = ST_IDLE;
                wait_nxt  = 1'h1;
            end
        endcase
    end

    // Read data is loaded when a read is taken and then stands
    // until the next read answer
    always @* begin
        rdata_nxt = O_READDATA;
        if (take_rd) begin
            if (sel_cap)
                rdata_nxt = cap_word;
            else if (sel_ctrl)
                rdata_nxt = {31'h0000_0000, unlock_r};
            else
                rdata_nxt = 32'h0000_0000;
        end
    end

    // Lockable fields take a write only while unlocked; the unlock bit
    // itself is always writable; writes to other addresses are dropped
    always @* begin
        unlock_nxt  = unlock_r;
        mps_nxt     = mps_r;
        ext_tag_nxt = ext_tag_r;
        if (take_wr && sel_ctrl && lane0_write(1'h1, I_BYTEENABLE))
            unlock_nxt = I_WRITEDATA[`CTRL_UNLOCK_BIT];
        if (take_wr && sel_cap && lane0_write(unlock_r, I_BYTEENABLE)) begin
            mps_nxt     = I_WRITEDATA[`MPS_MSB:`MPS_LSB];
            ext_tag_nxt = I_WRITEDATA[`EXT_TAG_BIT];
        end
    end

    // Handshake registers; waitrequest is high through reset
    always @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            state_r       <= ST_IDLE;
            O_WAITREQUEST <= 1'h1;
        end else begin
            state_r       <= state_nxt;
            O_WAITREQUEST <= wait_nxt;
        end
    end

    // Read data register
    always @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N)
            O_READDATA <= 32'h0000_0000;
        else
            O_READDATA <= rdata_nxt;
    end

    // Lockable field registers; reset restores the advertised defaults
    // even if software changed them while unlocked
    always @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            mps_r     <= `MPS_RESET;
            ext_tag_r <= `EXT_TAG_RESET;
        end else begin
            mps_r     <= mps_nxt;
            ext_tag_r <= ext_tag_nxt;
        end
    end

    // Unlock register; the port comes out of reset locked
    always @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N)
            unlock_r <= 1'h0;
        else
            unlock_r <= unlock_nxt;
    end
endmodule // device_capabilities_register

// File: core/power_limit_capture.v
`timescale 1ns/1ps
`include "devcap_map.vh"
module power_limit_capture (
    input  wire       i_clk,        // Core clock
    input  wire       i_rst_n,      // Async reset, active low
    input  wire       i_upstream,   // Port is upstream
    input  wire       i_msg_valid,  // Power-limit message received
    input  wire [7:0] i_msg_value,  // Message value
    input  wire [1:0] i_msg_scale,  // Message scale
    output reg  [7:0] o_value,      // Captured value
    output reg  [1:0] o_scale       // Captured scale
);
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_value <= `CPV_RESET;
            o_scale <= `CPS_RESET;
        end else if (!i_upstream) begin
            o_value <= `CPV_RESET;
            o_scale <= `CPS_RESET;
        end else if (i_msg_valid) begin
            o_value <= i_msg_value;
            o_scale <= i_msg_scale;
        end
    end
endmodule // power_limit_capture

// File: test/devcap_monitor.sv
`timescale 1ns/1ps
module devcap_monitor (
    input wire        I_CORE_CLK,              // Clock
    input wire        I_RST_N,                 // Reset, active low
    input wire        I_UPSTREAM,              // Port role
    input wire        I_MSG_VALID,             // Message strobe
    input wire [7:0]  I_MSG_VALUE,             // Message value
    input wire [1:0]  I_MSG_SCALE,             // Message scale
    input wire [11:0] I_ADDRESS,               // Bus address
    input wire        I_READ,                  // Bus read
    input wire        I_WRITE,                 // Bus write
    input wire [31:0] O_READDATA,              // Read data
    input wire        O_WAITREQUEST            // Wait request
);
    reg        hit_r;
    reg [9:0]  exp_r;
    wire       ans = hit_r && !O_WAITREQUEST;
    // Tracks the answer cycle of a capability read and the last message
    always @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            hit_r <= 1'b0;
            exp_r <= 10'h000;
        end else begin
            hit_r <= I_READ && O_WAITREQUEST && I_ADDRESS == 12'h044;
            if (I_MSG_VALID)
                exp_r <= {I_MSG_SCALE, I_MSG_VALUE};
        end
    end
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_RST_N);
    chk_phantom_zero: assert property (ans |-> O_READDATA[4:3] == 2'h0) else $error("phantom field");
    chk_lat_zero: assert property (ans |-> O_READDATA[11:6] == 6'h00) else $error("latency");
    chk_ind_zero: assert property (ans |-> O_READDATA[14:12] == 3'h0) else $error("indicators");
    chk_role_err: assert property (ans |-> O_READDATA[15]) else $error("role error bit");
    chk_cap_value: assert property (ans && I_UPSTREAM |-> O_READDATA[25:18] == exp_r[7:0]) else $error("value");
    chk_cap_scale: assert property (ans && I_UPSTREAM |-> O_READDATA[27:26] == exp_r[9:8]) else $error("scale");
    chk_down_zero: assert property (ans && !I_UPSTREAM |-> O_READDATA[27:18] == 10'h000) else $error("down");
    chk_one_wait: assert property ((I_READ || I_WRITE) && O_WAITREQUEST |=> !O_WAITREQUEST ##1 O_WAITREQUEST)
        else $error("wait cycle");
    cover property (ans && I_UPSTREAM);
    cover property (ans && !I_UPSTREAM);
    cover property (I_MSG_VALID && I_UPSTREAM);
endmodule // devcap_monitor

// File: test/device_capabilities_register_test.sv
`timescale 1ns/1ps
module device_capabilities_register_test;
    reg         clk = 1'b0, rst_n = 1'b0, up = 1'b1, rd = 1'b0, wr = 1'b0;
    reg  [11:0] adr = 12'h000;
    reg  [31:0] wd = 32'h00000000, q;
    reg  [3:0]  be = 4'hF;
    wire [31:0] rdata;
    wire        wt, mv;
    wire [7:0]  mval;
    wire [1:0]  msc;
    integer     err_count = 0, checked = 0, s;
    always #25 clk = ~clk;
    power_msg_source power_msg_source_i (.i_clk(clk), .o_valid(mv), .o_value(mval), .o_scale(msc));
    device_capabilities_register device_capabilities_register_i (.I_CORE_CLK(clk), .I_RST_N(rst_n),
        .I_UPSTREAM(up), .I_MSG_VALID(mv), .I_MSG_VALUE(mval), .I_MSG_SCALE(msc), .I_ADDRESS(adr), .I_READ(rd),
        .I_WRITE(wr), .I_WRITEDATA(wd), .I_BYTEENABLE(be), .O_READDATA(rdata), .O_WAITREQUEST(wt));
    task close_out;
        begin
            $display("checked %0d mismatches %0d", checked, err_count);
            if (err_count == 0 && checked > 0) $display("Run complete: PASS");
            else $display("Run complete: FAIL");
            $finish;
        end
    endtask
    task restart(input u);
        begin
            rst_n <= 1'b0;
            up <= u;
            repeat (20) @(posedge clk);
            rst_n <= 1'b1;
        end
    endtask
    task bus(input w, input [11:0] a, input [31:0] d);
        integer n;
        begin
            n = 0;
            @(posedge clk);
            {rd, wr, adr, wd} <= {!w, w, a, d};
            do begin @(posedge clk); n = n + 1; end while (wt !== 1'b0 && n < 20);
            q = rdata;
            {rd, wr} <= 2'b00;
            if (n >= 20) begin err_count = err_count + 1; close_out; end
        end
    endtask
    task rdc(input [11:0] a, input [31:0] e, input string nm);
        begin
            bus(1'b0, a, 32'h00000000);
            checked = checked + 1;
            if (q !== e) begin err_count = err_count + 1; $display("wrong value %s expected %h seen %h", nm, e, q); end
        end
    endtask
    initial begin
        restart(1'b1);
        rdc(12'h044, 32'h00008024, "reset word");
        rdc(12'h100, 32'h00000000, "unmapped");
        bus(1'b1, 12'h044, 32'h00000000);
        rdc(12'h044, 32'h00008024, "locked write");
        bus(1'b1, 12'h0F0, 32'h00000001);
        bus(1'b1, 12'h044, 32'hFFFFFFFF);
        rdc(12'h044, 32'h00008027, "unlocked ones");
        bus(1'b1, 12'h044, 32'h00000000);
        rdc(12'h044, 32'h00008000, "unlocked zeros");
        be <= 4'hE;
        bus(1'b1, 12'h044, 32'hFFFFFFFF);
        be <= 4'hF;
        rdc(12'h044, 32'h00008000, "lane masked");
        $display("lock test done");
        for (s = 0; s < 4; s = s + 1) begin
            power_msg_source_i.send(8'hC3 ^ s[7:0], s[1:0]);
            rdc(12'h044, {4'h0, s[1:0], 8'hC3 ^ s[7:0], 18'h08000}, "captured");
        end
        $display("upstream test done");
        restart(1'b0);
        power_msg_source_i.send(8'hFF, 2'h3);
        rdc(12'h044, 32'h00008024, "downstream");
        $display("downstream test done");
        close_out;
    end
endmodule // device_capabilities_register_test
bind device_capabilities_register devcap_monitor devcap_monitor_i (.I_CORE_CLK, .I_RST_N, .I_UPSTREAM,
    .I_MSG_VALID, .I_MSG_VALUE, .I_MSG_SCALE, .I_ADDRESS, .I_READ, .I_WRITE, .O_READDATA, .O_WAITREQUEST);

// File: test/power_msg_source.sv
`timescale 1ns/1ps
module power_msg_source (
    input  wire       i_clk,   // Core clock
    output reg        o_valid, // Message strobe
    output reg  [7:0] o_value, // Power value
    output reg  [1:0] o_scale  // Power scale
);
    initial {o_valid, o_value, o_scale} = 11'h000;
    // One-cycle message; fields turn over afterwards so stale data is not trusted
    task send(input [7:0] v, input [1:0] s);
        begin
            @(posedge i_clk);
            {o_valid, o_value, o_scale} <= {1'b1, v, s};
            @(posedge i_clk);
            {o_valid, o_value, o_scale} <= {1'b0, ~v, ~s};
        end
    endtask
endmodule // power_msg_source
